// File: logic/asrc_pkg.sv
package asrc_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CLK_NS = 40;
  // timing of the slowest grade
  localparam int T_RC_NS = 120;
  localparam int T_AS_NS = 0;
  localparam int T_WP_NS = 70;
  localparam int T_WR_NS = 5;
  localparam int T_OHZ_NS = 40;
  localparam int T_RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_AS_CYC = (T_AS_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 : (T_AS_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WR_CYC = (T_WR_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_OHZ_CYC = (T_OHZ_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 3;
  typedef enum logic [2:0] {
    ASRC_IDLE  = 3'h0,
    ASRC_RSET  = 3'h1,
    ASRC_RWAIT = 3'h2,
    ASRC_WSET  = 3'h3,
    ASRC_WPUL  = 3'h4,
    ASRC_WREC  = 3'h5,
    ASRC_TURN  = 3'h6,
    ASRC_SLEEP = 3'h7
  } asrc_state_type;
endpackage

// File: logic/asrc_sync.sv
`timescale 1ns/1ps
module asrc_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } asrc_sync_type;
  asrc_sync_type r;
  asrc_sync_type next_r;
  always_comb begin
    next_r = r;
    if (ce_i) begin
      next_r.s1 = d_i;
      next_r.s2 = r.s1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign q_o = r.s2;
endmodule

// File: logic/asrc_host.sv
`timescale 1ns/1ps
module asrc_host (
  input  wire logic                        SYS_CLK_I,
  input  wire logic                        RST_N_I,
  input  wire logic                        CE_I,
  input  wire logic                        REQ_I,
  input  wire logic                        WR_I,
  input  wire logic [asrc_pkg::ADDR_W-1:0] ADDR_I,
  input  wire logic [asrc_pkg::DATA_W-1:0] WDATA_I,
  input  wire logic                        SLEEP_I,
  output logic                             READY_O,
  output logic                             DONE_O,
  output logic      [asrc_pkg::DATA_W-1:0] RDATA_O,
  output logic                             RETAIN_OK_O,
  output logic      [asrc_pkg::ADDR_W-1:0] MEM_ADDR_O,
  output logic                             MEM_SEL_N_O,
  output logic                             MEM_SEL_O,
  output logic                             MEM_OE_N_O,
  output logic                             MEM_WE_N_O,
  input  wire logic [asrc_pkg::DATA_W-1:0] MEM_DQ_I,
  output logic      [asrc_pkg::DATA_W-1:0] MEM_DQ_O,
  output logic                             MEM_DQ_OE_O
);
  typedef struct packed {
    asrc_pkg::asrc_state_type    st;
    logic [asrc_pkg::CNT_W-1:0]  cnt;
    logic [asrc_pkg::ADDR_W-1:0] addr;
    logic [asrc_pkg::DATA_W-1:0] wdata;
    logic [asrc_pkg::DATA_W-1:0] rdata;
    logic                        sel;
    logic                        oe;
    logic                        we;
    logic                        dq_oe;
    logic                        done;
    logic                        wake;
  } asrc_host_type;

  asrc_host_type r;
  asrc_host_type next_r;
  logic [asrc_pkg::DATA_W-1:0] dq_sync;

  // data pins are asynchronous to this clock
  asrc_sync #(.W(asrc_pkg::DATA_W)) u_dq_sync (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .d_i     (MEM_DQ_I),
    .q_o     (dq_sync)
  );

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    case (r.st)
      asrc_pkg::ASRC_IDLE: begin
        next_r.sel = 1'b0;
        next_r.oe  = 1'b0;
        next_r.we  = 1'b0;
        if (r.wake) begin
          // recovery wait after supply returns
          if (r.cnt == asrc_pkg::CNT_W'(asrc_pkg::T_RC_CYC - 1)) begin
            next_r.wake = 1'b0;
          end else begin
            next_r.cnt = r.cnt + 1'b1;
          end
        end else if (SLEEP_I) begin
          next_r.st = asrc_pkg::ASRC_SLEEP; // deselected already, zero lead
        end else if (REQ_I) begin
          // address latched only while strobe is high
          next_r.addr  = ADDR_I;
          next_r.wdata = WDATA_I;
          next_r.cnt   = '0;
          next_r.sel   = 1'b1; // both selects together
          next_r.st    = WR_I ? asrc_pkg::ASRC_WSET : asrc_pkg::ASRC_RSET;
        end
      end
      asrc_pkg::ASRC_RSET: begin
        next_r.oe = 1'b1; // memory drives only now
        next_r.st = asrc_pkg::ASRC_RWAIT;
      end
      asrc_pkg::ASRC_RWAIT: begin
        // access time plus two synchroniser stages
        if (r.cnt == asrc_pkg::CNT_W'(asrc_pkg::T_RC_CYC + 1)) begin
          next_r.rdata = dq_sync;
          next_r.done  = 1'b1;
          next_r.oe    = 1'b0;
          next_r.sel   = 1'b0; // deselect floats the bus
          next_r.cnt   = '0;
          next_r.st    = asrc_pkg::ASRC_TURN;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      asrc_pkg::ASRC_WSET: begin
        // output enable held off; host drives dq
        next_r.dq_oe = 1'b1;
        next_r.we    = 1'b1; // strobe falls after select settles
        next_r.cnt   = '0;
        next_r.st    = asrc_pkg::ASRC_WPUL;
      end
      asrc_pkg::ASRC_WPUL: begin
        if (r.cnt == asrc_pkg::CNT_W'(asrc_pkg::T_WP_CYC - 1)) begin
          next_r.we  = 1'b0; // strobe rise ends the write
          next_r.cnt = '0;
          next_r.st  = asrc_pkg::ASRC_WREC;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      asrc_pkg::ASRC_WREC: begin
        // data held one cycle past the ending edge
        next_r.dq_oe = 1'b0;
        next_r.sel   = 1'b0;
        next_r.done  = 1'b1;
        next_r.cnt   = '0;
        next_r.st    = asrc_pkg::ASRC_TURN;
      end
      asrc_pkg::ASRC_TURN: begin
        // bus release time before the next access
        if (r.cnt == asrc_pkg::CNT_W'(asrc_pkg::T_OHZ_CYC - 1)) begin
          next_r.cnt = '0;
          next_r.st  = asrc_pkg::ASRC_IDLE;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      asrc_pkg::ASRC_SLEEP: begin
        if (!SLEEP_I) begin
          next_r.wake = 1'b1;
          next_r.cnt  = '0;
          next_r.st   = asrc_pkg::ASRC_IDLE;
        end
      end
      default: begin
        next_r.st = asrc_pkg::ASRC_IDLE;
      end
    endcase
    if (!CE_I) begin
      next_r = r;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign READY_O     = (r.st == asrc_pkg::ASRC_IDLE) && !r.wake && !SLEEP_I;
  assign DONE_O      = r.done;
  assign RDATA_O     = r.rdata;
  assign RETAIN_OK_O = (r.st == asrc_pkg::ASRC_SLEEP);
  assign MEM_ADDR_O  = r.addr;
  assign MEM_SEL_N_O = !r.sel;
  assign MEM_SEL_O   = r.sel;
  assign MEM_OE_N_O  = !r.oe;
  assign MEM_WE_N_O  = !r.we;
  assign MEM_DQ_O    = r.wdata;
  assign MEM_DQ_OE_O = r.dq_oe;

  addr_stable_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    !$stable(MEM_ADDR_O) |-> $past(MEM_WE_N_O) && MEM_WE_N_O)
    else $error("address moved during write strobe");
  no_contend_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    !(MEM_DQ_OE_O && !MEM_OE_N_O))
    else $error("host drives while memory output enabled");
  sel_pair_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (MEM_SEL_O != MEM_SEL_N_O) && (MEM_SEL_O || (MEM_WE_N_O && MEM_OE_N_O)))
    else $error("selects disagree or strobe while deselected");
  we_needs_sel_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    $fell(MEM_WE_N_O) |-> $past(MEM_SEL_O) && MEM_DQ_OE_O)
    else $error("strobe fell without prior select");
  pulse_width_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I || !CE_I)
    $fell(MEM_WE_N_O) |-> !MEM_WE_N_O [*2] ##1 MEM_WE_N_O)
    else $error("write pulse not two cycles");
  data_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    $rose(MEM_WE_N_O) |-> MEM_DQ_OE_O && $stable(MEM_DQ_O))
    else $error("write data not held at strobe rise");
  sleep_desel_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    RETAIN_OK_O |-> !MEM_SEL_O && MEM_WE_N_O)
    else $error("selected during retention");
  read_done_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I || !CE_I)
    $rose(MEM_SEL_O) && MEM_WE_N_O ##1 !MEM_OE_N_O |-> ##[1:8] DONE_O)
    else $error("read did not complete");
  // sequencing of the memory pins and the host handshake across accesses
  oe_off_write_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    !MEM_WE_N_O |-> MEM_OE_N_O)
    else $error("output enable active during write");
  read_oe_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    !MEM_OE_N_O |-> MEM_SEL_O && MEM_WE_N_O && !MEM_DQ_OE_O)
    else $error("output enable outside a read");
  write_drive_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    !MEM_WE_N_O |-> MEM_DQ_OE_O && MEM_SEL_O)
    else $error("write strobe without data or select");
  wdata_steady_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    MEM_DQ_OE_O |-> $stable(MEM_DQ_O))
    else $error("write data moved while driven");
  addr_steady_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    MEM_SEL_O && $past(MEM_SEL_O) |-> $stable(MEM_ADDR_O))
    else $error("address moved while selected");
  ready_quiet_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    READY_O |-> !MEM_SEL_O && MEM_WE_N_O && MEM_OE_N_O && !MEM_DQ_OE_O)
    else $error("ready while memory pins busy");
  wake_wait_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    $fell(RETAIN_OK_O) |-> !READY_O [*3])
    else $error("access allowed before recovery time");
  retain_quiet_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    RETAIN_OK_O |-> MEM_OE_N_O && !MEM_DQ_OE_O)
    else $error("pins active during retention");
  write_done_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I || !CE_I)
    $fell(MEM_WE_N_O) |-> ##3 DONE_O)
    else $error("write did not complete in time");
  read_end_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    $rose(MEM_OE_N_O) |-> !MEM_SEL_O && DONE_O)
    else $error("read end without deselect");
  turn_gap_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    $fell(MEM_SEL_O) |=> !MEM_SEL_O)
    else $error("no turnaround between accesses");
  rdata_load_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    !$stable(RDATA_O) |-> DONE_O)
    else $error("read data changed outside read end");
endmodule

// File: tb/asrc_sram_model.sv
`timescale 1ns/1ps
module asrc_sram_model (
  input  wire logic                        sel_n_i,
  input  wire logic                        sel_i,
  input  wire logic                        oe_n_i,
  input  wire logic                        we_n_i,
  input  wire logic [asrc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [asrc_pkg::DATA_W-1:0] bus_i,
  input  wire logic                        host_oe_i,
  output logic      [asrc_pkg::DATA_W-1:0] dq_o,
  output logic                             viol_o
);
  logic [asrc_pkg::DATA_W-1:0] mem [0:(2**asrc_pkg::ADDR_W)-1];
  logic [asrc_pkg::DATA_W-1:0] last;
  logic                        sel;
  logic                        drv;
  assign sel = !sel_n_i && sel_i;
  assign drv = sel && we_n_i && !oe_n_i;
  // released pins show the inverse of the last driven byte
  assign dq_o = drv ? mem[addr_i] : ~last;
  initial begin
    last = 8'h00;
    viol_o = 1'b0;
  end
  always @* begin
    if (drv) begin
      last = mem[addr_i];
    end
  end
  // level write: the value kept is the one present when the overlap ends
  always @* begin
    if (sel && !we_n_i) begin
      mem[addr_i] = bus_i;
    end
  end
  always @* begin
    if (drv && host_oe_i) begin
      viol_o = 1'b1;
    end
  end
  always @(addr_i) begin
    if (!we_n_i) begin
      viol_o = 1'b1;
    end
  end
endmodule

// File: tb/asrc_host_tb.sv
`timescale 1ns/1ps
module asrc_host_tb;
  logic       clk   = 1'b0;
  logic       rst_n = 1'b0;
  logic       req   = 1'b0;
  logic       wr    = 1'b0;
  logic       sleep = 1'b0;
  logic       ce    = 1'b1;
  logic [16:0] addr  = 17'h0;
  logic [7:0] wdata = 8'h00;
  logic       ready, done, retain, sel_n, sel, oe_n, we_n, dq_oe, viol;
  logic [7:0] rdata, hdq, mdq, bus;
  logic [16:0] maddr;
  int         err_total = 0;
  int         tests_run = 0;
  always #20 clk = ~clk;
  assign bus = dq_oe ? hdq : mdq;
  asrc_host dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .REQ_I(req), .WR_I(wr), .ADDR_I(addr),
    .WDATA_I(wdata), .SLEEP_I(sleep), .READY_O(ready), .DONE_O(done), .RDATA_O(rdata),
    .RETAIN_OK_O(retain), .MEM_ADDR_O(maddr), .MEM_SEL_N_O(sel_n), .MEM_SEL_O(sel), .MEM_OE_N_O(oe_n),
    .MEM_WE_N_O(we_n), .MEM_DQ_I(bus), .MEM_DQ_O(hdq), .MEM_DQ_OE_O(dq_oe));
  asrc_sram_model mem (.sel_n_i(sel_n), .sel_i(sel), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(maddr),
    .bus_i(bus), .host_oe_i(dq_oe), .dq_o(mdq), .viol_o(viol));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic access(input logic w, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    req = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    // ready is settled at the falling edge and stands until the taking edge
    while (ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    req = 1'b0;
    while (done !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk("done", 8'h01, {7'h0, done});
  endtask
  task automatic test_idle_pins();
    chk("idle pins", 8'h16, {3'h0, sel_n, sel, oe_n, we_n, dq_oe});
    $display("idle pins test done");
  endtask
  task automatic test_write_read();
    logic [16:0] a [3];
    logic [7:0]  d [3];
    a = '{17'h00000, 17'h1ffff, 17'h0a55a};
    d = '{8'ha5, 8'h5a, 8'hff};
    for (int i = 0; i < 3; i++) access(1'b1, a[i], d[i]);
    for (int i = 0; i < 3; i++) begin
      access(1'b0, a[i], 8'h00);
      chk("read back", d[i], rdata);
    end
    access(1'b1, 17'h00000, 8'h3c);
    access(1'b0, 17'h00000, 8'h00);
    chk("overwrite", 8'h3c, rdata);
    access(1'b0, 17'h00123, 8'h00);
    chk("unwritten", 8'hxx, rdata);
    $display("write read test done");
  endtask
  task automatic test_retention();
    int n;
    n = 0;
    @(negedge clk);
    sleep = 1'b1;
    while (retain !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("retain pins", 8'h06, {5'h0, retain, sel_n, sel});
    sleep = 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("recovery", 8'h01, {7'h0, n >= asrc_pkg::T_RC_CYC});
    access(1'b0, 17'h1ffff, 8'h00);
    chk("retained", 8'h5a, rdata);
    $display("retention test done");
  endtask
  task automatic test_freeze();
    @(negedge clk);
    ce = 1'b0;
    req = 1'b1;
    wr = 1'b0;
    addr = 17'h0a55a;
    repeat (4) @(negedge clk);
    chk("frozen pins", 8'h16, {3'h0, sel_n, sel, oe_n, we_n, dq_oe});
    chk("frozen done", 8'h00, {7'h0, done});
    req = 1'b0;
    ce = 1'b1;
    access(1'b0, 17'h0a55a, 8'h00);
    chk("after freeze", 8'hff, rdata);
    $display("clock enable test done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    test_idle_pins();
    test_write_read();
    test_freeze();
    test_retention();
    chk("bus rules", 8'h00, {7'h0, viol});
    stop_test();
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule
